/* File: bsc_top.sv */
// bsc_top: branch control of a five-stage sequencer pipeline
// assumes the decoder presents one branch per cycle in decode, qualified by br_valid
`timescale 1ns/1ps
`default_nettype none
module bsc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic br_valid,
    input wire bsc_pkg::bsc_op_t br_op,
    input wire logic [bsc_pkg::ADDR_W-1:0] br_pc,
    input wire logic delayed_branch_option,
    input wire logic indirect,
    input wire logic pc_relative,
    input wire logic [bsc_pkg::ADDR_W-1:0] br_imm,
    input wire logic [bsc_pkg::ADDR_W-1:0] program_memory_address_generator,
    input wire logic [bsc_pkg::COND_W-1:0] cond_sel,
    input wire logic [bsc_pkg::STAT_W-1:0] status_flags,
    input wire logic loop_abort_option,
    input wire logic loop_reentry_option,
    input wire logic clear_interrupt_option,
    input wire logic [bsc_pkg::IRQ_W-1:0] irq_serviced,
    input wire logic [bsc_pkg::STAT_W-1:0] irq_raise,
    input wire logic sts_push,
    input wire logic [bsc_pkg::STAT_W-1:0] arith_status_in,
    input wire logic [bsc_pkg::STAT_W-1:0] mode_in,
    output logic fetch_redirect,
    output logic [bsc_pkg::ADDR_W-1:0] fetch_addr,
    output logic suppress_decode,
    output logic irq_defer,
    output logic [bsc_pkg::STAT_W-1:0] interrupt_latch_reg,
    output logic [bsc_pkg::STAT_W-1:0] interrupt_mask_pointer_reg,
    output logic [bsc_pkg::STAT_W-1:0] arith_status_reg,
    output logic [bsc_pkg::STAT_W-1:0] mode_control_reg,
    output logic [bsc_pkg::ADDR_W-1:0] pcstk_top,
    output logic [bsc_pkg::PCSTK_PTR_W-1:0] pcstk_ptr
);
    localparam int AW = bsc_pkg::ADDR_W;
    localparam int SW = bsc_pkg::STAT_W;

    function automatic logic [SW-1:0] bit_of(input logic [bsc_pkg::IRQ_W-1:0] idx);
        bit_of = bsc_pkg::ZERO_WORD;
        bit_of[idx] = 1'b1;
    endfunction

    // ==========================================
    // condition
    logic cond_ok;
    bsc_cond_eval u_cond (
        .clk(clk),
        .rst(rst),
        .cond_sel(cond_sel),
        .status_flags(status_flags),
        .cond_true(cond_ok)
    );

    // ==========================================
    // branch decode
    logic is_branch;
    logic taken;
    logic is_call;
    logic [AW-1:0] direct_tgt;
    logic [AW-1:0] tgt;
    logic opt_seen;
    always_comb begin
        is_branch = br_valid && (br_op != bsc_pkg::BSC_OP_NONE);
        taken = is_branch && cond_ok;
        is_call = br_op == bsc_pkg::BSC_OP_CALL;
        direct_tgt = pc_relative ? AW'(br_pc + br_imm) : br_imm;
        tgt = indirect ? program_memory_address_generator : direct_tgt;
        opt_seen = loop_abort_option | loop_reentry_option | clear_interrupt_option;
    end

    // ==========================================
    // sequencing state
    bsc_pkg::bsc_state_t st_q, st_d;
    logic [1:0] db_cnt_q, db_cnt_d;
    bsc_pkg::bsc_op_t op_q, op_d;
    logic [AW-1:0] tgt_q, tgt_d;
    logic [AW-1:0] ret_q, ret_d;
    logic [bsc_pkg::IRQ_W-1:0] svc_q, svc_d;
    logic redir_q, redir_d;
    logic [AW-1:0] faddr_q, faddr_d;
    logic supp_q, supp_d;
    logic defer_q, defer_d;
    logic do_push;
    logic do_pop;
    logic [AW-1:0] push_val;
    logic opt_q;

    always_comb begin
        st_d = st_q;
        db_cnt_d = db_cnt_q;
        op_d = op_q;
        tgt_d = tgt_q;
        ret_d = ret_q;
        svc_d = svc_q;
        redir_d = 1'b0;
        faddr_d = faddr_q;
        supp_d = 1'b0;
        defer_d = 1'b0;
        do_push = 1'b0;
        do_pop = 1'b0;
        push_val = ret_q;
        unique case (st_q)
            bsc_pkg::BSC_ST_IDLE: begin
                if (taken) begin
                    op_d = br_op;
                    tgt_d = tgt;
                    svc_d = irq_serviced;
                    if (delayed_branch_option) begin
                        ret_d = AW'(br_pc + bsc_pkg::ADDR_THREE);
                        st_d = bsc_pkg::BSC_ST_DB;
                        db_cnt_d = 2'(bsc_pkg::DB_SLOTS - 1);
                        defer_d = 1'b1;
                    end else begin
                        ret_d = AW'(br_pc + bsc_pkg::ADDR_ONE);
                        st_d = bsc_pkg::BSC_ST_ABT1;
                        supp_d = 1'b1;
                    end
                end
            end
            bsc_pkg::BSC_ST_ABT1: begin
                supp_d = 1'b1;
                st_d = bsc_pkg::BSC_ST_ABT2;
                redir_d = 1'b1;
                do_push = op_q == bsc_pkg::BSC_OP_CALL;
                do_pop = (op_q == bsc_pkg::BSC_OP_RTS) || (op_q == bsc_pkg::BSC_OP_RTI);
                faddr_d = do_pop ? pcstk_top : tgt_q;
            end
            bsc_pkg::BSC_ST_ABT2: begin
                supp_d = 1'b1;
                st_d = bsc_pkg::BSC_ST_ABT3;
            end
            bsc_pkg::BSC_ST_ABT3: begin
                st_d = bsc_pkg::BSC_ST_IDLE;
            end
            bsc_pkg::BSC_ST_DB: begin
                defer_d = 1'b1;
                if (db_cnt_q == 2'(bsc_pkg::DB_SLOTS - 1)) begin
                    redir_d = 1'b1;
                    do_push = op_q == bsc_pkg::BSC_OP_CALL;
                    do_pop = (op_q == bsc_pkg::BSC_OP_RTS) || (op_q == bsc_pkg::BSC_OP_RTI);
                    faddr_d = do_pop ? pcstk_top : tgt_q;
                    db_cnt_d = 2'(db_cnt_q - 2'h1);
                end else begin
                    supp_d = 1'b1;
                    st_d = bsc_pkg::BSC_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= bsc_pkg::BSC_ST_IDLE;
            db_cnt_q <= 2'h0;
            op_q <= bsc_pkg::BSC_OP_NONE;
            tgt_q <= bsc_pkg::RESET_ADDR;
            ret_q <= bsc_pkg::RESET_ADDR;
            svc_q <= '0;
            redir_q <= 1'b0;
            faddr_q <= bsc_pkg::RESET_ADDR;
            supp_q <= 1'b0;
            defer_q <= 1'b0;
            opt_q <= 1'b0;
        end else begin
            st_q <= st_d;
            db_cnt_q <= db_cnt_d;
            op_q <= op_d;
            tgt_q <= tgt_d;
            ret_q <= ret_d;
            svc_q <= svc_d;
            redir_q <= redir_d;
            faddr_q <= faddr_d;
            supp_q <= supp_d;
            defer_q <= defer_d;
            opt_q <= opt_seen;
        end
    end

    // ==========================================
    // return-address stack
    logic [AW-1:0] pcstk_q [bsc_pkg::PCSTK_DEPTH];
    logic [AW-1:0] pcstk_d [bsc_pkg::PCSTK_DEPTH];
    logic [bsc_pkg::PCSTK_PTR_W-1:0] pptr_q, pptr_d;
    always_comb begin
        pcstk_d = pcstk_q;
        pptr_d = pptr_q;
        if (do_push && (pptr_q < 5'(bsc_pkg::PCSTK_DEPTH))) begin
            pcstk_d[pptr_q] = push_val;
            pptr_d = 5'(pptr_q + 5'h01);
        end else if (do_pop && (pptr_q != 5'h00)) begin
            pptr_d = 5'(pptr_q - 5'h01);
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < bsc_pkg::PCSTK_DEPTH; gi++) begin : g_pcstk
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pcstk_q[gi] <= bsc_pkg::RESET_ADDR;
                end else begin
                    pcstk_q[gi] <= pcstk_d[gi];
                end
            end
        end
    endgenerate
    logic [AW-1:0] top_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pptr_q <= 5'h00;
            top_q <= bsc_pkg::RESET_ADDR;
        end else begin
            pptr_q <= pptr_d;
            top_q <= (pptr_d == 5'h00) ? bsc_pkg::RESET_ADDR : pcstk_d[5'(pptr_d - 5'h01)];
        end
    end

    // ==========================================
    // interrupt and status state
    localparam logic [SW-1:0] STS_PUSH_MASK_W = bsc_pkg::STS_PUSH_MASK;
    logic rti_pop;
    logic [SW-1:0] latch_q, latch_d, maskp_q, maskp_d, astat_q, astat_d, mode_q, mode_d;
    logic [SW-1:0] sts_a_q [bsc_pkg::STS_DEPTH];
    logic [SW-1:0] sts_m_q [bsc_pkg::STS_DEPTH];
    logic [SW-1:0] sts_a_d [bsc_pkg::STS_DEPTH];
    logic [SW-1:0] sts_m_d [bsc_pkg::STS_DEPTH];
    logic [bsc_pkg::STS_PTR_W-1:0] sptr_q, sptr_d;
    always_comb begin
        // interrupt return, irq_raise, sts_push and the status inputs all change this state
        rti_pop = do_pop && (op_q == bsc_pkg::BSC_OP_RTI);
        latch_d = latch_q;
        maskp_d = maskp_q;
        astat_d = arith_status_in;
        mode_d = mode_in;
        sts_a_d = sts_a_q;
        sts_m_d = sts_m_q;
        sptr_d = sptr_q;
        if (rti_pop) begin
            latch_d = latch_d & ~bit_of(svc_q);
            maskp_d = maskp_d & ~bit_of(svc_q);
        end
        // raising an interrupt wins over the clear
        latch_d = latch_d | irq_raise;
        maskp_d = maskp_d | irq_raise;
        if (rti_pop && ((STS_PUSH_MASK_W & bit_of(svc_q)) != bsc_pkg::ZERO_WORD)
            && (sptr_q != 4'h0)) begin
            sptr_d = 4'(sptr_q - 4'h1);
            astat_d = sts_a_q[sptr_d];
            mode_d = sts_m_q[sptr_d];
        end else if (sts_push && (sptr_q < 4'(bsc_pkg::STS_DEPTH))) begin
            sts_a_d[sptr_q] = arith_status_in;
            sts_m_d[sptr_q] = mode_in;
            sptr_d = 4'(sptr_q + 4'h1);
        end
    end
    generate
        for (gi = 0; gi < bsc_pkg::STS_DEPTH; gi++) begin : g_sts
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    sts_a_q[gi] <= bsc_pkg::ZERO_WORD;
                    sts_m_q[gi] <= bsc_pkg::ZERO_WORD;
                end else begin
                    sts_a_q[gi] <= sts_a_d[gi];
                    sts_m_q[gi] <= sts_m_d[gi];
                end
            end
        end
    endgenerate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_q <= bsc_pkg::ZERO_WORD;
            maskp_q <= bsc_pkg::ZERO_WORD;
            astat_q <= bsc_pkg::ZERO_WORD;
            mode_q <= bsc_pkg::ZERO_WORD;
            sptr_q <= 4'h0;
        end else begin
            latch_q <= latch_d;
            maskp_q <= maskp_d;
            astat_q <= astat_d;
            mode_q <= mode_d;
            sptr_q <= sptr_d;
        end
    end

    assign fetch_redirect = redir_q;
    assign fetch_addr = faddr_q;
    assign suppress_decode = supp_q;
    assign irq_defer = defer_q;
    assign interrupt_latch_reg = latch_q;
    assign interrupt_mask_pointer_reg = maskp_q;
    assign arith_status_reg = astat_q;
    assign mode_control_reg = mode_q;
    assign pcstk_top = top_q;
    assign pcstk_ptr = pptr_q;

    // ==========================================
    // checks
    sequence s_imm_start;
        st_q == bsc_pkg::BSC_ST_IDLE && taken && !delayed_branch_option;
    endsequence
    AST_IMM_ABORT3: assert property (@(posedge clk) disable iff (rst)
        s_imm_start |=> supp_q ##1 supp_q ##1 supp_q ##1 !supp_q)
        else $error("immediate branch abort count wrong");
    AST_IMM_REDIR: assert property (@(posedge clk) disable iff (rst)
        s_imm_start |=> !redir_q ##1 redir_q)
        else $error("immediate redirect late");
    AST_CALL_PUSH: assert property (@(posedge clk) disable iff (rst)
        (st_q == bsc_pkg::BSC_ST_IDLE && taken && !delayed_branch_option && is_call)
        |=> ##1 (pptr_q == $past(pptr_q) + 5'h01 || pptr_q == 5'(bsc_pkg::PCSTK_DEPTH)))
        else $error("call did not push");
    AST_JUMP_NOPUSH: assert property (@(posedge clk) disable iff (rst)
        (st_q == bsc_pkg::BSC_ST_IDLE && taken && !delayed_branch_option
            && br_op == bsc_pkg::BSC_OP_JUMP) |=> ##1 $stable(pptr_q))
        else $error("jump changed stack");
    AST_RET_TARGET: assert property (@(posedge clk) disable iff (rst)
        (do_pop) |=> fetch_addr == $past(pcstk_top))
        else $error("return target not stack top");
    AST_RTS_KEEP: assert property (@(posedge clk) disable iff (rst)
        (do_pop && op_q == bsc_pkg::BSC_OP_RTS && irq_raise == bsc_pkg::ZERO_WORD)
        |=> $stable(latch_q))
        else $error("subroutine return touched latch");
    AST_RTI_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (rti_pop && irq_raise == bsc_pkg::ZERO_WORD) |=> !latch_q[$past(svc_q)])
        else $error("interrupt bit not cleared");
    AST_FALSE_COND: assert property (@(posedge clk) disable iff (rst)
        (st_q == bsc_pkg::BSC_ST_IDLE && is_branch && !cond_ok) |=> !supp_q && !redir_q)
        else $error("false condition aborted");
    AST_DB_SLOTS: assert property (@(posedge clk) disable iff (rst)
        (st_q == bsc_pkg::BSC_ST_IDLE && taken && delayed_branch_option)
        |=> (!supp_q && !redir_q) ##1 (!supp_q && redir_q) ##1 supp_q)
        else $error("delayed branch overhead wrong");
    AST_DB_DEFER: assert property (@(posedge clk) disable iff (rst)
        (st_q == bsc_pkg::BSC_ST_IDLE && taken && delayed_branch_option) |=> irq_defer[*3])
        else $error("interrupt not deferred");
endmodule
`default_nettype wire

/* File: bsc_pkg.sv */
// bsc_pkg: constants and types for the branch sequencer control block
// assumes a 24-bit program address space and a 32-bit status path
package bsc_pkg;
    localparam int ADDR_W = 24;
    localparam int STAT_W = 32;
    localparam int IRQ_W = 5;
    localparam int PCSTK_DEPTH = 30;
    localparam int PCSTK_PTR_W = 5;
    localparam int STS_DEPTH = 15;
    localparam int STS_PTR_W = 4;
    localparam int COND_W = 5;
    // number of aborted slots of an immediate branch
    localparam int IMM_LOST = 3;
    // delayed branch: slots executed before the aborted one
    localparam int DB_SLOTS = 2;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h080000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 24'h000001;
    localparam logic [ADDR_W-1:0] ADDR_THREE = 24'h000003;
    localparam logic [COND_W-1:0] COND_TRUE = 5'h1f;
    // mask of interrupts whose return pops the status stack
    localparam logic [STAT_W-1:0] STS_PUSH_MASK = 32'h000001f0;
    localparam logic [STAT_W-1:0] ZERO_WORD = 32'h00000000;

    typedef enum logic [2:0] {
        BSC_OP_NONE = 3'h0,
        BSC_OP_JUMP = 3'h1,
        BSC_OP_CALL = 3'h2,
        BSC_OP_RTS = 3'h3,
        BSC_OP_RTI = 3'h4
    } bsc_op_t;

    typedef enum logic [4:0] {
        BSC_ST_IDLE = 5'b00001,
        BSC_ST_ABT1 = 5'b00010,
        BSC_ST_ABT2 = 5'b00100,
        BSC_ST_ABT3 = 5'b01000,
        BSC_ST_DB = 5'b10000
    } bsc_state_t;
endpackage

/* File: bsc_cond_eval.sv */
// bsc_cond_eval: combinational evaluation of a branch condition
// assumes status flags are stable in the cycle the branch is decoded
`timescale 1ns/1ps
`default_nettype none
module bsc_cond_eval (
    input wire logic clk,
    input wire logic rst,
    input wire logic [bsc_pkg::COND_W-1:0] cond_sel,
    input wire logic [bsc_pkg::STAT_W-1:0] status_flags,
    output logic cond_true
);
    logic cond_d;
    logic cond_q;

    // ==========================================
    // condition select
    always_comb begin
        cond_d = 1'b1;
        if (cond_sel != bsc_pkg::COND_TRUE) begin
            cond_d = status_flags[cond_sel];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cond_q <= 1'b0;
        end else begin
            cond_q <= cond_d;
        end
    end

    assign cond_true = cond_d;
endmodule
`default_nettype wire

/* File: bsc_fetch_model.sv */
// bsc_fetch_model: far side of the sequencer, address generator and fetch unit
// assumes the sequencer redirects fetch with a one-cycle fetch_redirect pulse
`timescale 1ns/1ps
`default_nettype none
module bsc_fetch_model #(
    parameter logic [bsc_pkg::ADDR_W-1:0] AGEN_SEED = 24'h000c40,
    parameter logic [bsc_pkg::ADDR_W-1:0] AGEN_STEP = 24'h000008
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic fetch_redirect,
    input wire logic [bsc_pkg::ADDR_W-1:0] fetch_addr,
    output logic [bsc_pkg::ADDR_W-1:0] agen_addr,
    output logic [bsc_pkg::ADDR_W-1:0] fetch_pc
);
    // ==========================================
    // address generator and fetch counter
    logic [bsc_pkg::ADDR_W-1:0] agen_d;
    logic [bsc_pkg::ADDR_W-1:0] fpc_d;
    // indirect target source
    // post-modify after each redirect, so a stale target shows up
    always_comb begin
        agen_d = fetch_redirect ? agen_addr + AGEN_STEP : agen_addr;
        fpc_d = fetch_redirect ? fetch_addr : fetch_pc + bsc_pkg::ADDR_ONE;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            agen_addr <= AGEN_SEED;
            fetch_pc <= bsc_pkg::RESET_ADDR;
        end else begin
            agen_addr <= agen_d;
            fetch_pc <= fpc_d;
        end
    end
endmodule
`default_nettype wire

/* File: bsc_top_bench.sv */
// bsc_top_bench: self-checking bench for the branch sequencer control
// assumes bsc_top and bsc_fetch_model; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module bsc_top_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic br_valid = 1'b0;
    bsc_pkg::bsc_op_t br_op = bsc_pkg::BSC_OP_NONE;
    logic [23:0] br_pc = 24'h000000;
    logic db = 1'b0;
    logic ind = 1'b0;
    logic rel = 1'b0;
    logic [23:0] br_imm = 24'h000000;
    logic [4:0] cond_sel = 5'h1f;
    logic [31:0] status_flags = 32'h00000000;
    logic lopt = 1'b0;
    logic [4:0] irq_serviced = 5'h00;
    logic [31:0] irq_raise = 32'h00000000;
    logic sts_push = 1'b0;
    logic [31:0] arith_in = 32'h00000000;
    logic [31:0] mode_in = 32'h00000000;
    wire logic fetch_redirect, suppress_decode, irq_defer;
    wire logic [23:0] fetch_addr, pcstk_top, agen, fetch_pc;
    wire logic [31:0] latch, maskp, arith, mode;
    wire logic [4:0] pcstk_ptr;
    int miscompares = 0;
    int checks_done = 0;
    int n_supp, supp_first, supp_last, redir_at, n_defer;
    logic [31:0] g_addr, g_ptr, g_top, g_latch, g_maskp, g_arith, g_mode, agen_at;

    always #25 clk = ~clk;

    bsc_top dut (.clk(clk), .rst(rst), .br_valid(br_valid), .br_op(br_op), .br_pc(br_pc),
        .delayed_branch_option(db), .indirect(ind), .pc_relative(rel), .br_imm(br_imm),
        .program_memory_address_generator(agen), .cond_sel(cond_sel),
        .status_flags(status_flags), .loop_abort_option(lopt), .loop_reentry_option(lopt),
        .clear_interrupt_option(lopt), .irq_serviced(irq_serviced), .irq_raise(irq_raise),
        .sts_push(sts_push), .arith_status_in(arith_in), .mode_in(mode_in),
        .fetch_redirect(fetch_redirect), .fetch_addr(fetch_addr),
        .suppress_decode(suppress_decode), .irq_defer(irq_defer),
        .interrupt_latch_reg(latch), .interrupt_mask_pointer_reg(maskp),
        .arith_status_reg(arith), .mode_control_reg(mode), .pcstk_top(pcstk_top),
        .pcstk_ptr(pcstk_ptr));
    bsc_fetch_model model (.clk(clk), .rst(rst), .fetch_redirect(fetch_redirect),
        .fetch_addr(fetch_addr), .agen_addr(agen), .fetch_pc(fetch_pc));

    // ==========================================
    // shared checking and bus tasks
    task automatic give_verdict();
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one branch in decode for one cycle, then seven cycles observed
    task automatic run_br(input bsc_pkg::bsc_op_t op, input logic d, input logic i,
            input logic r, input logic [23:0] pc, input logic [23:0] imm, input logic [4:0] cs);
        @(negedge clk);
        br_op = op;
        db = d;
        ind = i;
        rel = r;
        br_pc = pc;
        br_imm = imm;
        cond_sel = cs;
        br_valid = 1'b1;
        agen_at = {8'h00, agen};
        n_supp = 0;
        n_defer = 0;
        supp_first = -1;
        supp_last = -1;
        redir_at = -1;
        for (int k = 0; k < 7; k++) begin
            @(negedge clk);
            br_valid = 1'b0;
            br_op = bsc_pkg::BSC_OP_NONE;
            if (suppress_decode === 1'b1) begin
                if (n_supp == 0) supp_first = k;
                supp_last = k;
                n_supp++;
            end
            if (irq_defer === 1'b1) n_defer++;
            if (fetch_redirect === 1'b1) begin
                redir_at = k;
                g_addr = {8'h00, fetch_addr};
                g_ptr = {27'h0000000, pcstk_ptr};
                g_top = {8'h00, pcstk_top};
                g_latch = latch;
                g_maskp = maskp;
                g_arith = arith;
                g_mode = mode;
            end
        end
    endtask
    task automatic chk_imm(input logic [31:0] tgt);
        chk(n_supp, 3);
        chk(supp_last - supp_first, 2);
        chk(redir_at, supp_first + 1);
        chk(g_addr, tgt);
        chk({8'h00, fetch_pc}, tgt + 32'h00000004);
    endtask

    // ==========================================
    // scenarios
    task automatic t_jump();
        lopt = 1'b1;
        run_br(bsc_pkg::BSC_OP_JUMP, 1'b0, 1'b0, 1'b0, 24'h000100, 24'h000400, 5'h1f);
        lopt = 1'b0;
        chk_imm(32'h00000400);
        chk(g_ptr, 0);
    endtask
    task automatic t_call_rel();
        run_br(bsc_pkg::BSC_OP_CALL, 1'b0, 1'b0, 1'b1, 24'h000200, 24'h000010, 5'h1f);
        chk_imm(32'h00000210);
        chk(g_ptr, 1);
        chk(g_top, 32'h00000201);
    endtask
    task automatic t_call_db();
        run_br(bsc_pkg::BSC_OP_CALL, 1'b1, 1'b1, 1'b0, 24'h000300, 24'h000000, 5'h1f);
        chk(g_addr, agen_at);
        chk(n_supp, 1);
        chk(redir_at, supp_first - 1);
        chk(n_defer, 3);
        chk(g_ptr, 2);
        chk(g_top, 32'h00000303);
    endtask
    task automatic t_cond();
        status_flags = 32'h00000000;
        run_br(bsc_pkg::BSC_OP_JUMP, 1'b0, 1'b0, 1'b0, 24'h000500, 24'h000600, 5'h03);
        chk(n_supp, 0);
        chk(redir_at, -1);
        chk({27'h0000000, pcstk_ptr}, 2);
        status_flags = 32'h00000008;
        run_br(bsc_pkg::BSC_OP_CALL, 1'b0, 1'b0, 1'b0, 24'h000500, 24'h000600, 5'h03);
        chk_imm(32'h00000600);
        chk(g_ptr, 3);
        run_br(bsc_pkg::BSC_OP_RTS, 1'b0, 1'b0, 1'b0, 24'h000600, 24'h000000, 5'h1f);
        chk_imm(32'h00000501);
    endtask
    task automatic t_returns();
        @(negedge clk);
        irq_raise = 32'h00000010;
        sts_push = 1'b1;
        arith_in = 32'h0000a5a5;
        mode_in = 32'h00003c3c;
        @(negedge clk);
        irq_raise = 32'h00000000;
        sts_push = 1'b0;
        arith_in = 32'h00001111;
        mode_in = 32'h00002222;
        irq_serviced = 5'h04;
        run_br(bsc_pkg::BSC_OP_RTS, 1'b0, 1'b0, 1'b0, 24'h000700, 24'h000000, 5'h1f);
        chk_imm(32'h00000303);
        chk(g_ptr, 1);
        chk(g_latch & 32'h10, 32'h10);
        chk(g_maskp & 32'h10, 32'h10);
        chk(g_arith, 32'h00001111);
        run_br(bsc_pkg::BSC_OP_RTI, 1'b0, 1'b0, 1'b0, 24'h000800, 24'h000000, 5'h1f);
        chk_imm(32'h00000201);
        chk(g_ptr, 0);
        chk(g_latch & 32'h10, 0);
        chk(g_maskp & 32'h10, 0);
        chk(g_arith, 32'h0000a5a5);
        chk(g_mode, 32'h00003c3c);
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk({8'h00, fetch_addr}, {8'h00, bsc_pkg::RESET_ADDR});
        chk({27'h0000000, pcstk_ptr}, 0);
        t_jump();
        t_call_rel();
        t_call_db();
        t_cond();
        t_returns();
        give_verdict();
    end
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
